// ---- core/ddr_io_element.sv ----
// one i/o block: ahb-lite config, data buffer and its ddr i/o elements
`timescale 1ns/10ps
`default_nettype none

module io_elem (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [31:0] cfg,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_oe,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_ce,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_clk,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_clr,
    input wire logic el_oe,
    input wire logic el_ce_in,
    input wire logic el_ce_out,
    input wire logic el_clk,
    input wire logic el_clr,
    input wire logic pad_s,
    input wire logic tx_ok,
    input wire logic tx_a,
    input wire logic tx_b,
    output logic take,
    output logic rx_hi,
    output logic rx_lo,
    output logic rx_stb,
    output logic pad_out,
    output logic pad_oe_n
);
    import ddr_io_pkg::*;

    elem_st_t q, d;
    logic [1:0] mode;
    logic pv, ckin, ckout, cei, ceo, aclr, sclr, oe_src, din;
    logic in_rise, in_fall, out_rise, out_fall;
    logic ddr_in, ddr_out, out_used, en, en_f, mx;

    always_comb begin
        d = q;
        mode = cfg[F_MODE +: 2];
        pv = cfg[F_PRESET];
        // every control has its own source choice per element
        ckin = pick_src(cfg[F_CKIN +: 3], blk_clk, el_clk);
        ckout = pick_src(cfg[F_CKOUT +: 3], blk_clk, el_clk);
        cei = cfg[F_DLY_CE] ? q.ce_in_q
                            : pick_src(cfg[F_CEIN +: 3], blk_ce, el_ce_in);
        ceo = cfg[F_DLY_CE] ? q.ce_out_q
                            : pick_src(cfg[F_CEOUT +: 3], blk_ce, el_ce_out);
        aclr = cfg[F_ACLR_EN] & pick_src(cfg[F_ACLR +: 3], blk_clr, el_clr);
        sclr = cfg[F_SCLR_EN] & pick_src(cfg[F_SCLR +: 3], blk_clr, el_clr);
        oe_src = pick_src(cfg[F_OE +: 3], blk_oe, el_oe);
        // i/o clocks arrive as levels sampled on clk_sys
        in_rise = ckin & ~q.ckin;
        in_fall = ~ckin & q.ckin;
        out_rise = ckout & ~q.ckout;
        out_fall = ~ckout & q.ckout;
        ddr_in = (mode == MODE_DDR_IN) || (mode == MODE_DDR_BIDIR);
        ddr_out = (mode == MODE_DDR_OUT) || (mode == MODE_DDR_BIDIR);
        out_used = mode != MODE_DDR_IN;
        din = cfg[F_DLY_IN] ? q.pad_dly : pad_s;
        take = out_rise & ceo & out_used & ~aclr & ~sclr & q.up;
        d.ckin = ckin;
        d.ckout = ckout;
        d.ce_in_q = pick_src(cfg[F_CEIN +: 3], blk_ce, el_ce_in);
        d.ce_out_q = pick_src(cfg[F_CEOUT +: 3], blk_ce, el_ce_out);
        d.pad_dly = pad_s;
        d.rx_stb = 1'b0;
        // input side runs on its own clock and enable
        if (in_rise) begin
            if (sclr) begin
                d.pos = pv;
                d.neg = pv;
                d.lat = pv;
            end else if (cei) begin
                d.pos = din;
                d.rx_lo = din;
                d.rx_hi = ddr_in ? q.lat : din;
                d.rx_stb = 1'b1;
            end
        end
        if (in_fall && ddr_in) begin
            if (sclr) begin
                d.neg = pv;
            end else if (cei) begin
                d.neg = din;
            end
        end
        // latch open while the clock is low, so the high-time bit survives
        if (!ckin && ddr_in) begin
            d.lat = d.neg;
        end
        // output and oe registers share clock and enable
        if (out_rise && out_used) begin
            if (sclr) begin
                d.oa = pv;
                d.ob = pv;
                d.oe_pos = pv;
            end else if (ceo) begin
                if (tx_ok) begin
                    d.oa = tx_a;
                    d.ob = tx_b;
                end
                d.oe_pos = oe_src;
            end
        end
        if (out_fall && mode == MODE_DDR_BIDIR) begin
            if (sclr) begin
                d.oe_neg = pv;
            end else if (ceo) begin
                d.oe_neg = q.oe_pos;
            end
        end
        case (mode)
            MODE_DDR_IN: begin
                en = 1'b0;
            end
            MODE_DDR_BIDIR: begin
                // falling-edge copy holds the enable back half a period
                en = q.oe_pos & q.oe_neg;
            end
            default: begin
                en = q.oe_pos;
            end
        endcase
        d.en_prev = en;
        // turn-on delay only; turn-off stays immediate to avoid contention
        en_f = cfg[F_DLY_OE] ? (en & q.en_prev) : en;
        mx = (ddr_out && !ckout) ? q.ob : q.oa;
        d.odly = mx;
        d.pad_out = cfg[F_DLY_OUT] ? q.odly : mx;
        d.pad_oe_n = ~en_f;
        // power-up level, and clear/preset beating every other term
        if (!q.up || aclr) begin
            d.up = 1'b1;
            d.pos = pv;
            d.neg = pv;
            d.lat = pv;
            d.oa = pv;
            d.ob = pv;
            d.oe_pos = pv;
            d.oe_neg = pv;
            d.rx_stb = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.pad_oe_n <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign rx_hi = q.rx_hi;
    assign rx_lo = q.rx_lo;
    assign rx_stb = q.rx_stb;
    assign pad_out = q.pad_out;
    assign pad_oe_n = q.pad_oe_n;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_ddr_in_rise: assert property (
        ce && ddr_in && in_rise && cei && !sclr && !aclr && q.up
        |=> q.pos == $past(din) && q.rx_hi == $past(q.lat) && q.rx_stb)
        else $error("ddr input pair not captured on rising edge");
    chk_latch_hold: assert property (
        ce && ddr_in && ckin && !in_rise && !aclr && q.up |=> $stable(q.lat))
        else $error("input latch moved during clock high");
    chk_out_load: assert property (
        ce && take && tx_ok
        |=> q.oa == $past(tx_a) && q.ob == $past(tx_b))
        else $error("output pair not loaded on rising edge");
    chk_out_mux: assert property (
        ce && ddr_out && !cfg[F_DLY_OUT]
        |=> pad_out == $past(ckout ? q.oa : q.ob))
        else $error("pin bit does not follow clock level");
    chk_oe_falling: assert property (
        ce && mode == MODE_DDR_BIDIR && !q.oe_neg |=> pad_oe_n)
        else $error("bidir pin driven before falling edge");
    chk_common_clock: assert property (
        ce && !aclr && q.up && !out_rise
        |=> $stable(q.oa) && $stable(q.ob) && $stable(q.oe_pos))
        else $error("output or oe register moved off its clock");
    chk_in_indep: assert property (
        ce && !aclr && q.up && !in_rise |=> $stable(q.pos) && $stable(q.rx_hi))
        else $error("input register moved off its clock");
    chk_clear_shared: assert property (
        ce && aclr |=> q.pos == q.oa && q.neg == q.oe_pos && q.ob == q.oe_neg)
        else $error("registers left on different clear levels");
    chk_powerup: assert property (
        ce && !q.up |=> q.up && q.lat == $past(pv) && q.oe_neg == $past(pv))
        else $error("power-up level not applied");
    chk_sync_reset: assert property (
        ce && in_rise && sclr && !aclr && q.up
        |=> q.pos == $past(pv) && q.neg == $past(pv))
        else $error("synchronous reset missed");
    chk_oe_turnon: assert property (
        ce && cfg[F_DLY_OE] && en && !q.en_prev |=> pad_oe_n)
        else $error("oe turn-on delay skipped");
    chk_aclr_override: assert property (
        ce && aclr |=> q.pos == $past(pv) && q.oa == $past(pv) && !q.rx_stb)
        else $error("clear did not override clocked update");

    cov_ddr_in_pair: cover property (ce && ddr_in && in_rise && cei);
    cov_bidir_drive: cover property (mode == MODE_DDR_BIDIR && !pad_oe_n);
    cov_aclr: cover property (ce && aclr && q.up);
endmodule : io_elem

module ddr_io_element #(
    parameter int n_elem = ddr_io_pkg::ROW_ELEMS
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_oe,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_ce,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_clk,
    input wire logic [ddr_io_pkg::BUNDLE_PER_KIND-1:0] blk_clr,
    input wire logic [n_elem-1:0] el_oe,
    input wire logic [n_elem-1:0] el_ce_in,
    input wire logic [n_elem-1:0] el_ce_out,
    input wire logic [n_elem-1:0] el_clk,
    input wire logic [n_elem-1:0] el_clr,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [n_elem-1:0] tx_data_a,
    input wire logic [n_elem-1:0] tx_data_b,
    output logic [n_elem-1:0] rx_hi,
    output logic [n_elem-1:0] rx_lo,
    output logic [n_elem-1:0] rx_stb,
    input wire logic [n_elem-1:0] pad_in,
    output logic [n_elem-1:0] pad_out,
    output logic [n_elem-1:0] pad_oe_n
);
    import ddr_io_pkg::*;

    localparam int N = n_elem;

    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic a_valid;
        logic a_write;
        logic a_word;
        logic [7:0] a_addr;
        logic [31:0] rdata;
        logic [N-1:0][31:0] sel;
        logic [1:0][2*N-1:0] ent;
        logic [1:0] cnt;
    } top_st_t;

    top_st_t q, d;
    logic [N-1:0] take;
    logic push, pop;
    logic ent_idx;

    // row blocks carry four elements, column blocks six
    assign tx_ready = q.cnt != 2'd2;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;

    always_comb begin
        d = q;
        // first stage feeds only the second
        d.sync1 = pad_in;
        d.sync2 = q.sync1;
        if (q.a_valid && q.a_write && q.a_word) begin
            for (int i = 0; i < N; i++) begin
                if (q.a_addr == OFS_SEL_BASE + 8'(4 * i)) begin
                    d.sel[i] = hwdata;
                end
            end
        end
        d.a_valid = hsel && hready && htrans[1];
        if (d.a_valid) begin
            d.a_write = hwrite;
            d.a_addr = haddr[7:0];
            d.a_word = (hsize == HSIZE_WORD) && (haddr[31:8] == 24'h0);
            if (!hwrite) begin
                // reads see a write still in its data phase
                d.rdata = 32'h0;
                if (haddr[31:8] == 24'h0) begin
                    if (haddr[7:0] == OFS_STATUS) begin
                        d.rdata[ST_PAD_LSB +: N] = q.sync2;
                        d.rdata[ST_CNT_LSB +: 2] = q.cnt;
                    end else if (haddr[7:0] == OFS_CAPTURE) begin
                        d.rdata[CAP_LO_LSB +: N] = rx_lo;
                        d.rdata[CAP_HI_LSB +: N] = rx_hi;
                    end
                    for (int i = 0; i < N; i++) begin
                        if (haddr[7:0] == OFS_SEL_BASE + 8'(4 * i)) begin
                            d.rdata = d.sel[i];
                        end
                    end
                end
            end
        end
        // two-entry buffer; entry 0 is always the head
        push = tx_valid && tx_ready;
        pop = (q.cnt != 2'd0) && (|take);
        ent_idx = pop ? 1'(q.cnt - 2'd1) : q.cnt[0];
        if (pop) begin
            d.ent[0] = q.ent[1];
        end
        if (push) begin
            d.ent[ent_idx] = {tx_data_a, tx_data_b};
        end
        d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // one instance per element, all fed from the shared bundle
    for (genvar g = 0; g < N; g++) begin : g_el
        io_elem u_el (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .ce(ce),
            .cfg(q.sel[g]),
            .blk_oe(blk_oe),
            .blk_ce(blk_ce),
            .blk_clk(blk_clk),
            .blk_clr(blk_clr),
            .el_oe(el_oe[g]),
            .el_ce_in(el_ce_in[g]),
            .el_ce_out(el_ce_out[g]),
            .el_clk(el_clk[g]),
            .el_clr(el_clr[g]),
            .pad_s(q.sync2[g]),
            .tx_ok(q.cnt != 2'd0),
            .tx_a(q.ent[0][N + g]),
            .tx_b(q.ent[0][g]),
            .take(take[g]),
            .rx_hi(rx_hi[g]),
            .rx_lo(rx_lo[g]),
            .rx_stb(rx_stb[g]),
            .pad_out(pad_out[g]),
            .pad_oe_n(pad_oe_n[g])
        );
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_sel_write: assert property (
        ce && q.a_valid && q.a_write && q.a_word && q.a_addr == OFS_SEL_BASE
        |=> q.sel[0] == $past(hwdata))
        else $error("element select register not written");
    chk_buf_full: assert property (
        ce && q.cnt == 2'd2 && !pop |=> q.cnt == 2'd2 && !tx_ready)
        else $error("buffer accepts while full");
    chk_buf_count: assert property (
        ce && push && !pop |=> q.cnt == $past(q.cnt) + 2'd1)
        else $error("buffer count lost a push");
    chk_pad_sync: assert property (
        ce ##1 ce |=> q.sync2 == $past(pad_in, 2))
        else $error("pin input not resynchronised in two stages");

    cov_buf_full: cover property (q.cnt == 2'd2 && tx_valid);
endmodule : ddr_io_element

`default_nettype wire

// ---- core/ddr_io_pkg.sv ----
// constants, field layout and shared types for the ddr i/o block
// What this block does
// - each element has pin buffer, two capture regs plus latch, two out, two oe
// - ddr input captures on both edges; latch aligns both bits to one edge
// - ddr output loads both regs on rise; clock level picks which bit drives
// - bidirectional ddr keeps enable off until the falling edge
// - oe and output regs share one clock and one clock enable
// - input regs take their own clock and clock enable
// - all regs of an element share one clear-or-preset source
// - regs power up high or low; low pairs clear, high pairs preset
// - regs also take a synchronous reset on their own clock
// - each element picks its own control sources independently
// - block takes a shared bundle of sixteen control lines
// - row block holds up to four elements, column block six
// - row block takes 28 per-element lines including two data bits each
// - column block takes 42 per-element lines including twelve data lines
// - captured pin value is routed back to the fabric
// - elements offer input, output, clock-enable and oe turn-on delays
// - dedicated low-skew i/o clock lines serve the elements
package ddr_io_pkg;
    localparam int ROW_ELEMS = 4;
    localparam int COL_ELEMS = 6;
    localparam int BUNDLE_PER_KIND = 4;
    localparam int BUNDLE_LINES = 16;
    localparam int ROW_ELEM_LINES = 28;
    localparam int COL_ELEM_LINES = 42;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CAPTURE = 8'h04;
    localparam logic [7:0] OFS_SEL_BASE = 8'h10;
    localparam logic [31:0] SEL_RST = 32'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int F_OE = 0;
    localparam int F_CEIN = 3;
    localparam int F_CEOUT = 6;
    localparam int F_ACLR = 9;
    localparam int F_SCLR = 12;
    localparam int F_CKIN = 15;
    localparam int F_CKOUT = 18;
    localparam int F_MODE = 21;
    localparam int F_PRESET = 23;
    localparam int F_ACLR_EN = 24;
    localparam int F_SCLR_EN = 25;
    localparam int F_DLY_IN = 26;
    localparam int F_DLY_OUT = 27;
    localparam int F_DLY_OE = 28;
    localparam int F_DLY_CE = 29;
    localparam int ST_PAD_LSB = 0;
    localparam int ST_CNT_LSB = 8;
    localparam int CAP_LO_LSB = 0;
    localparam int CAP_HI_LSB = 8;
    localparam logic [1:0] MODE_SDR = 2'h0;
    localparam logic [1:0] MODE_DDR_IN = 2'h1;
    localparam logic [1:0] MODE_DDR_OUT = 2'h2;
    localparam logic [1:0] MODE_DDR_BIDIR = 2'h3;

    typedef struct packed {
        logic up;
        logic ckin;
        logic ckout;
        logic ce_in_q;
        logic ce_out_q;
        logic pad_dly;
        logic pos;
        logic neg;
        logic lat;
        logic oa;
        logic ob;
        logic oe_pos;
        logic oe_neg;
        logic en_prev;
        logic odly;
        logic pad_out;
        logic pad_oe_n;
        logic rx_hi;
        logic rx_lo;
        logic rx_stb;
    } elem_st_t;

    // source code: bit 2 picks the element's own line, else a bundle line
    function automatic logic pick_src(input logic [2:0] code,
                                      input logic [3:0] bundle,
                                      input logic own);
        return code[2] ? own : bundle[code[1:0]];
    endfunction : pick_src
endpackage : ddr_io_pkg

// ---- test/pin_model.sv ----
// far-side pin model: drives the pads source-synchronously
`timescale 1ns/10ps
`default_nettype none

module pin_model #(
    parameter int n = 4
) (
    input wire logic clk_sys,
    input wire logic io_clk,
    input wire logic send,
    input wire logic [n-1:0] bit_hi,
    input wire logic [n-1:0] bit_lo,
    input wire logic [n-1:0] pad_out,
    input wire logic [n-1:0] pad_oe_n,
    output logic [n-1:0] pad_in
);
    // data lags three cycles so it sits centred in each clock half
    logic [2:0] ck_q;
    logic [n-1:0] hi_q [3];
    logic [n-1:0] lo_q [3];
    logic [n-1:0] idle_q;
    logic [n-1:0] far;

    initial begin
        ck_q = '0;
        hi_q = '{default: '0};
        lo_q = '{default: '0};
        idle_q = '0;
    end

    // plain always: the initial block above also writes these
    always @(posedge clk_sys) begin
        ck_q <= {ck_q[1:0], io_clk};
        hi_q <= '{bit_hi, hi_q[0], hi_q[1]};
        lo_q <= '{bit_lo, lo_q[0], lo_q[1]};
        // toggle from the model's own level, never from an unknown pad
        idle_q <= ~far;
    end

    // with send low a released pad shows no stale level: it flips every cycle
    assign far = !send ? idle_q : (ck_q[2] ? hi_q[2] : lo_q[2]);
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & far);
endmodule : pin_model

`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench: bus, tx stream, ddr pins, clears
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import ddr_io_pkg::*;
    localparam int PH = 6;
    localparam int NE = ROW_ELEMS;
    localparam logic [31:0] SEL0 = 32'(OFS_SEL_BASE);
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, tx_ready;
    logic [31:0] hrdata;
    logic [3:0] blk_clr = '0;
    logic [NE-1:0] el_oe = '0, el_ce_in = '1, el_ce_out = '1, el_clr = '0;
    logic [NE-1:0] el_clk, rx_hi, rx_lo, rx_stb, pad_in, pad_out, pad_oe_n;
    logic [NE-1:0] tx_data_a = '0, tx_data_b = '0, hi = '0, lo = '0;
    logic tx_valid = 1'b0;
    logic ce = 1'b1;
    logic io_ck = 1'b0;
    logic send = 1'b0;
    logic rd_ph = 1'b0;
    logic cap_on = 1'b0;
    logic [31:0] rd_q [$];
    logic [1:0] cap_q [$];
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    assign el_clk = {NE{io_ck}};

    ddr_io_element #(.n_elem(NE)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .blk_oe(4'h0), .blk_ce(4'h0),
        .blk_clk(4'h0), .blk_clr(blk_clr), .el_oe(el_oe),
        .el_ce_in(el_ce_in), .el_ce_out(el_ce_out), .el_clk(el_clk),
        .el_clr(el_clr), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data_a(tx_data_a), .tx_data_b(tx_data_b), .rx_hi(rx_hi),
        .rx_lo(rx_lo), .rx_stb(rx_stb), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n)
    );

    pin_model #(.n(NE)) i_pins (
        .clk_sys(clk_sys), .io_clk(io_ck), .send(send), .bit_hi(hi),
        .bit_lo(lo), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_in(pad_in)
    );

    always #10 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // observers: results are matched against the oldest noted value
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rd_ph && hreadyout === 1'b1) begin
            check("hrdata", hrdata, rd_q.pop_front());
            check("hresp", hresp, 1'b0);
        end
        if (hreadyout === 1'b1) begin
            rd_ph <= htrans == 2'h2 && !hwrite && hsel;
        end
        if (cap_on && rx_stb[0] === 1'b1) begin
            check("capture", {rx_hi[0], rx_lo[0]}, cap_q.pop_front());
        end
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // no own limit: only the bench timeout ends a wait
    task automatic wait_rdy(input logic tx);
        @(negedge clk_sys);
        while ((tx ? tx_ready : hreadyout) !== 1'b1) begin
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
    endtask : wait_rdy

    // read: d is the expected word
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy(1'b0);
        htrans <= 2'h0;
        hwdata <= d;
        if (!wr) begin
            rd_q.push_back(d);
        end
        wait_rdy(1'b0);
        hsel <= 1'b0;
    endtask : bus

    task automatic push(input logic [NE-1:0] a, input logic [NE-1:0] b);
        @(posedge clk_sys);
        tx_valid <= 1'b1;
        tx_data_a <= a;
        tx_data_b <= b;
        wait_rdy(1'b1);
        tx_valid <= 1'b0;
    endtask : push

    // how: 0 no check, 1 pad level, 2 pad enable
    task automatic io_cycle(input int how, input logic ea, input logic eb);
        @(posedge clk_sys);
        io_ck <= 1'b1;
        repeat (PH) @(posedge clk_sys);
        if (how == 1) check("pad high", pad_out[0], ea);
        if (how == 2) check("oe high", pad_oe_n[0], ea);
        io_ck <= 1'b0;
        repeat (PH) @(posedge clk_sys);
        if (how == 1) check("pad low", pad_out[0], eb);
        if (how == 2) check("oe low", pad_oe_n[0], eb);
    endtask : io_cycle

    function automatic logic [31:0] sel(input logic [1:0] m);
        return (32'h4 << F_OE) | (32'h4 << F_CEIN) | (32'h4 << F_CEOUT)
            | (32'h4 << F_CKIN) | (32'h4 << F_CKOUT) | (32'(m) << F_MODE);
    endfunction : sel

    initial begin
        logic [31:0] r;
        logic [NE-1:0] a, b;
        void'($urandom(32'h10ef));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, SEL0, SEL_RST);
        // element 3: input-only on a dead bundle clock, so it never pops
        r = ($urandom & 32'h3f9d_ffff) | (32'(MODE_DDR_IN) << F_MODE);
        bus(1'b1, SEL0 + 12, r);
        bus(1'b0, SEL0 + 12, r);
        bus(1'b1, 32'h40, 32'hffff_ffff);
        bus(1'b0, 32'h40, 32'h0);
        // two words stored while the io clock stalls
        bus(1'b1, SEL0, sel(MODE_DDR_OUT));
        a = NE'($urandom);
        b = NE'($urandom);
        push(a, b);
        push(~a, ~b);
        @(negedge clk_sys);
        check("ready full", tx_ready, 1'b0);
        // clock enable low: an io clock pulse must not pop the buffer
        @(posedge clk_sys);
        ce <= 1'b0;
        io_cycle(0, 1'b0, 1'b0);
        ce <= 1'b1;
        check("ce freeze", tx_ready, 1'b0);
        io_cycle(1, a[0], b[0]);
        io_cycle(1, ~a[0], ~b[0]);
        io_cycle(1, ~a[0], ~b[0]);
        // sync clear waits for the element's own clock edge
        push('1, '1);
        io_cycle(0, 1'b0, 1'b0);
        bus(1'b1, SEL0, sel(MODE_DDR_OUT) | (32'h1 << F_SCLR_EN));
        blk_clr <= 4'h1;
        repeat (4) @(posedge clk_sys);
        check("sclr early", pad_out[0], 1'b1);
        io_cycle(1, 1'b0, 1'b0);
        blk_clr <= 4'h0;
        // async preset overrides the clock and holds the entry back
        bus(1'b1, SEL0, sel(MODE_DDR_OUT) | (32'h1 << F_PRESET)
            | (32'h1 << F_ACLR_EN) | (32'h4 << F_ACLR));
        el_clr <= '1;
        repeat (3) @(posedge clk_sys);
        check("preset", pad_out[0], 1'b1);
        push('0, '0);
        io_cycle(1, 1'b1, 1'b1);
        el_clr <= '0;
        io_cycle(1, 1'b0, 1'b0);
        // bidirectional: enable waits for the falling edge
        bus(1'b1, SEL0, sel(MODE_DDR_BIDIR) | (32'h1 << F_DLY_OE));
        io_cycle(0, 1'b0, 1'b0);
        el_oe <= '1;
        io_cycle(2, 1'b1, 1'b0);
        el_oe <= '0;
        // ddr capture from the far side
        bus(1'b1, SEL0, sel(MODE_DDR_IN));
        send <= 1'b1;
        hi <= NE'($urandom);
        lo <= NE'($urandom);
        io_cycle(0, 1'b0, 1'b0);
        cap_on = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cap_q.push_back({hi[0], lo[0]});
            hi <= NE'($urandom);
            lo <= NE'($urandom);
            io_cycle(0, 1'b0, 1'b0);
        end
        cap_q.push_back({hi[0], lo[0]});
        @(posedge clk_sys);
        io_ck <= 1'b1;
        repeat (PH) @(posedge clk_sys);
        cap_on = 1'b0;
        check("captures left", cap_q.size(), 32'h0);
        bus(1'b0, 32'(OFS_CAPTURE), (32'(hi[0]) << CAP_HI_LSB)
            | (32'(lo[0]) << CAP_LO_LSB));
        summarize();
    end
endmodule : testbench

`default_nettype wire
